/* design/i2cbp_core.v */
// two-wire bus protocol core: conditions, byte and ack framing, master flows
// Contract
// - start is sda falling while scl high, both sent and seen
// - stop is sda rising while scl high, both sent and seen
// - address and data bytes go out msb first
// - present slave acks address; roles then complement
// - acknowledge is low, driven by the receiver in the ack slot
// - data changes only while scl low; else it is a condition
// - each unit is eight data bits plus one ack bit
// - after eighth scl fall the sender releases sda and samples ack
// - master makes scl; sample on rise, change while low
// - slave may hold scl low; master waits for release
// - transmitter compares sda with driven level; mismatch loses arbitration
// - lines are open drain; low is zero, released is one
// - enabled port forces both pins open drain
// - pin output data is fixed at zero while enabled
// - repeated start resets slave logic like a start
// - stop valid only after one scl low period after start
`timescale 1ns/1ps
`default_nettype none
`include "i2cbp_defs.vh"
module i2cbp_core (
  // clock and reset
  input wire clock,
  input wire rst_n,
  // configuration
  input wire port_enable_bit,
  // bus clock line pins
  input wire bus_clock_line_in,
  output reg bus_clock_line_out,
  output reg bus_clock_line_oe,
  // bus data line pins
  input wire bus_data_line_in,
  output reg bus_data_line_out,
  output reg bus_data_line_oe,
  // command port, one byte per request
  input wire cmd_valid,
  output reg cmd_ready,
  input wire cmd_start,
  input wire cmd_stop,
  input wire cmd_read,
  input wire cmd_ack,
  input wire [7:0] cmd_data,
  // received bytes
  output reg rx_valid,
  input wire rx_ready,
  output reg [7:0] rx_data,
  // status
  output reg busy_ff,
  output reg nack_ff,
  output reg arb_lost_ff,
  output reg start_seen_ff,
  output reg stop_seen_ff,
  output reg [3:0] slave_bit_ff
);
  // master states
  localparam ST_IDLE = 3'h0;
  localparam ST_START = 3'h1;
  localparam ST_LOW = 3'h2;
  localparam ST_HIGH = 3'h3;
  localparam ST_STOP = 3'h4;
  localparam ST_WAIT = 3'h5;
  localparam ST_RSTRT = 3'h6;
  localparam [`I2CBP_DIV_W-1:0] HALF = `I2CBP_HALF_CYC;

  reg scl_s1_ff, scl_s2_ff, scl_d_ff;
  reg sda_s1_ff, sda_s2_ff, sda_d_ff;
  reg [2:0] state_ff;
  reg [`I2CBP_DIV_W-1:0] div_ff;
  reg [3:0] bit_ff;
  reg [7:0] shift_ff;
  reg rd_ff, ack_ff, stop_ff;
  reg drive_scl_ff, drive_sda_ff;
  reg low_seen_ff;
  reg [7:0] slv_shift_ff;
  wire tick;
  wire scl_rise, scl_fall, start_det, stop_det;
  wire buf_valid, buf_in_ready;
  wire nxt_cmd_ready;
  wire [7:0] buf_data;
  reg buf_push;
  reg [7:0] buf_wdata;

  // two-stage synchronisers on both lines
  always @(posedge clock) begin
    if (!rst_n) begin
      scl_s1_ff <= 1'b1;
      scl_s2_ff <= 1'b1;
      scl_d_ff <= 1'b1;
      sda_s1_ff <= 1'b1;
      sda_s2_ff <= 1'b1;
      sda_d_ff <= 1'b1;
    end else begin
      scl_s1_ff <= bus_clock_line_in;
      scl_s2_ff <= scl_s1_ff;
      scl_d_ff <= scl_s2_ff;
      sda_s1_ff <= bus_data_line_in;
      sda_s2_ff <= sda_s1_ff;
      sda_d_ff <= sda_s2_ff;
    end
  end

  // edge and condition detect on synchronised lines
  assign scl_rise = scl_s2_ff & ~scl_d_ff;
  assign scl_fall = ~scl_s2_ff & scl_d_ff;
  assign start_det = scl_s2_ff & scl_d_ff & ~sda_s2_ff & sda_d_ff;
  assign stop_det = scl_s2_ff & scl_d_ff & sda_s2_ff & ~sda_d_ff & low_seen_ff;
  assign tick = (div_ff == {`I2CBP_DIV_W{1'b0}});
  assign nxt_cmd_ready = (state_ff == ST_IDLE) & ~busy_ff & port_enable_bit & buf_in_ready & ~(cmd_valid & cmd_ready);

  // registered ready, dropped the cycle after a command is taken
  always @(posedge clock) begin
    if (!rst_n) begin
      cmd_ready <= 1'b0;
    end else begin
      cmd_ready <= nxt_cmd_ready;
    end
  end

  // bus monitor: busy tracking and slave bit counter
  always @(posedge clock) begin
    if (!rst_n) begin
      busy_ff <= 1'b0;
      low_seen_ff <= 1'b0;
      start_seen_ff <= 1'b0;
      stop_seen_ff <= 1'b0;
      slave_bit_ff <= `I2CBP_BIT_ZERO;
      slv_shift_ff <= 8'h00;
    end else begin
      start_seen_ff <= start_det;
      stop_seen_ff <= stop_det;
      if (start_det) begin
        busy_ff <= 1'b1;
        low_seen_ff <= 1'b0;
        slave_bit_ff <= `I2CBP_BIT_ZERO;
        slv_shift_ff <= 8'h00;
      end else if (stop_det) begin
        busy_ff <= 1'b0;
        low_seen_ff <= 1'b0;
        slave_bit_ff <= `I2CBP_BIT_ZERO;
      end else begin
        if (scl_fall) begin
          low_seen_ff <= 1'b1;
        end
        if (scl_rise) begin
          if (slave_bit_ff == `I2CBP_UNIT_LAST) begin
            slave_bit_ff <= `I2CBP_BIT_ZERO;
          end else begin
            slave_bit_ff <= slave_bit_ff + 4'h1;
            slv_shift_ff <= {slv_shift_ff[6:0], sda_s2_ff};
          end
        end
      end
    end
  end

  // bus-phase divider (scl high one phase, low two), one-cycle enable pulse
  always @(posedge clock) begin
    if (!rst_n) begin
      div_ff <= {`I2CBP_DIV_W{1'b0}};
    end else if (tick) begin
      div_ff <= HALF - {{(`I2CBP_DIV_W-1){1'b0}}, 1'b1};
    end else begin
      div_ff <= div_ff - {{(`I2CBP_DIV_W-1){1'b0}}, 1'b1};
    end
  end

  // master sequencer
  always @(posedge clock) begin
    if (!rst_n) begin
      state_ff <= ST_IDLE;
      bit_ff <= `I2CBP_BIT_ZERO;
      shift_ff <= 8'h00;
      rd_ff <= 1'b0;
      ack_ff <= 1'b0;
      stop_ff <= 1'b0;
      drive_scl_ff <= 1'b0;
      drive_sda_ff <= 1'b0;
      nack_ff <= 1'b0;
      arb_lost_ff <= 1'b0;
      buf_push <= 1'b0;
      buf_wdata <= 8'h00;
    end else begin
      buf_push <= 1'b0;
      if (!port_enable_bit) begin
        state_ff <= ST_IDLE;
        drive_scl_ff <= 1'b0;
        drive_sda_ff <= 1'b0;
      end else begin
        case (state_ff)
          ST_IDLE: begin
            drive_scl_ff <= 1'b0;
            drive_sda_ff <= 1'b0;
            if (cmd_valid & cmd_ready) begin
              shift_ff <= cmd_data;
              rd_ff <= cmd_read;
              ack_ff <= cmd_ack;
              stop_ff <= cmd_stop;
              bit_ff <= `I2CBP_BIT_ZERO;
              nack_ff <= 1'b0;
              arb_lost_ff <= 1'b0;
              state_ff <= cmd_start ? ST_START : ST_LOW;
            end
          end
          ST_START: begin
            if (tick) begin
              drive_sda_ff <= 1'b1;
              state_ff <= ST_RSTRT;
            end
          end
          ST_RSTRT: begin
            if (tick) begin
              drive_scl_ff <= 1'b1;
              state_ff <= ST_LOW;
            end
          end
          ST_LOW: begin
            if (tick) begin
              // place next bit while scl low
              drive_scl_ff <= 1'b1;
              if (bit_ff < `I2CBP_ACK_SLOT) begin
                drive_sda_ff <= rd_ff ? 1'b0 : ~shift_ff[`I2CBP_MSB];
              end else begin
                drive_sda_ff <= rd_ff ? ~ack_ff : 1'b0;
              end
              state_ff <= ST_WAIT;
            end
          end
          ST_WAIT: begin
            if (tick) begin
              drive_scl_ff <= 1'b0;
              state_ff <= ST_HIGH;
            end
          end
          ST_HIGH: begin
            // stretched clock holds us until scl reads high
            if (scl_s2_ff & tick) begin
              if ((bit_ff < `I2CBP_ACK_SLOT) & ~rd_ff & ~drive_sda_ff & ~sda_s2_ff) begin
                arb_lost_ff <= 1'b1;
                drive_sda_ff <= 1'b0;
                state_ff <= ST_IDLE;
              end else begin
                if (bit_ff < `I2CBP_ACK_SLOT) begin
                  shift_ff <= {shift_ff[6:0], sda_s2_ff};
                end else if (!rd_ff) begin
                  nack_ff <= sda_s2_ff;
                end
                if (bit_ff == `I2CBP_UNIT_LAST) begin
                  if (rd_ff) begin
                    buf_push <= 1'b1;
                    buf_wdata <= shift_ff;
                  end
                  state_ff <= stop_ff ? ST_STOP : ST_IDLE;
                  drive_scl_ff <= 1'b1;
                  drive_sda_ff <= 1'b1;
                end else begin
                  bit_ff <= bit_ff + 4'h1;
                  drive_scl_ff <= 1'b1;
                  state_ff <= ST_LOW;
                end
              end
            end
          end
          ST_STOP: begin
            if (tick) begin
              if (drive_scl_ff) begin
                drive_scl_ff <= 1'b0;
              end else if (scl_s2_ff) begin
                // a stretched clock delays the stop until scl reads high
                drive_sda_ff <= 1'b0;
                state_ff <= ST_IDLE;
              end
            end
          end
          default: begin
            state_ff <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // received bytes stand in a two-entry buffer
  i2cbp_buf u_buf (
    .clock(clock),
    .rst_n(rst_n),
    .in_valid(buf_push),
    .in_ready(buf_in_ready),
    .in_data(buf_wdata),
    .out_valid(buf_valid),
    .out_ready(rx_ready & ~rx_valid),
    .out_data(buf_data)
  );

  // registered rx outputs
  always @(posedge clock) begin
    if (!rst_n) begin
      rx_valid <= 1'b0;
      rx_data <= 8'h00;
    end else if (rx_valid & rx_ready) begin
      rx_valid <= 1'b0;
    end else if (buf_valid & rx_ready & ~rx_valid) begin
      rx_valid <= 1'b1;
      rx_data <= buf_data;
    end
  end

  // open-drain pins, data fixed low
  always @(posedge clock) begin
    if (!rst_n) begin
      bus_clock_line_out <= `I2CBP_PIN_LOW;
      bus_clock_line_oe <= 1'b0;
      bus_data_line_out <= `I2CBP_PIN_LOW;
      bus_data_line_oe <= 1'b0;
    end else begin
      bus_clock_line_out <= `I2CBP_PIN_LOW;
      bus_data_line_out <= `I2CBP_PIN_LOW;
      bus_clock_line_oe <= port_enable_bit & drive_scl_ff;
      bus_data_line_oe <= port_enable_bit & drive_sda_ff;
    end
  end
endmodule
`default_nettype wire

/* design/i2cbp_defs.vh */
// constants for the two-wire bus protocol core
`ifndef I2CBP_DEFS_VH
`define I2CBP_DEFS_VH
`define I2CBP_BYTE_BITS 4'h8
`define I2CBP_ACK_SLOT 4'h8
`define I2CBP_UNIT_LAST 4'h8
`define I2CBP_MSB 3'h7
`define I2CBP_BIT_ZERO 4'h0
`define I2CBP_ACK_LEVEL 1'b0
`define I2CBP_NACK_LEVEL 1'b1
`define I2CBP_PIN_LOW 1'b0
// one bus phase in system clocks, a third of the scl period: 2500 ns at 20 MHz, sized to the divider
`define I2CBP_HALF_CYC 8'h32
`define I2CBP_DIV_W 8
`define I2CBP_BUF_DEPTH 2
`endif

/* design/i2cbp_buf.v */
// two-entry valid/ready buffer for bytes
`timescale 1ns/1ps
`default_nettype none
module i2cbp_buf (
  // clock and reset
  input wire clock,
  input wire rst_n,
  // fill side
  input wire in_valid,
  output wire in_ready,
  input wire [7:0] in_data,
  // drain side
  output wire out_valid,
  input wire out_ready,
  output wire [7:0] out_data
);
  reg [7:0] mem_ff [0:1];
  reg wr_ff;
  reg rd_ff;
  reg [1:0] cnt_ff;
  wire push;
  wire pop;
  // honest full and empty
  assign in_ready = (cnt_ff != 2'h2);
  assign out_valid = (cnt_ff != 2'h0);
  assign out_data = mem_ff[rd_ff];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  // pointers, count, storage
  always @(posedge clock) begin
    if (!rst_n) begin
      wr_ff <= 1'b0;
      rd_ff <= 1'b0;
      cnt_ff <= 2'h0;
      mem_ff[0] <= 8'h00;
      mem_ff[1] <= 8'h00;
    end else begin
      if (push) begin
        mem_ff[wr_ff] <= in_data;
        wr_ff <= ~wr_ff;
      end
      if (pop) begin
        rd_ff <= ~rd_ff;
      end
      if (push & ~pop) begin
        cnt_ff <= cnt_ff + 2'h1;
      end else if (pop & ~push) begin
        cnt_ff <= cnt_ff - 2'h1;
      end
    end
  end
endmodule
`default_nettype wire

/* verif/i2cbp_core_props.sv */
// port assertions for the two-wire protocol core
`timescale 1ns/1ps
`default_nettype none
module i2cbp_core_props (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // pins and enable
  input wire logic port_enable_bit,
  input wire logic bus_clock_line_in,
  input wire logic bus_clock_line_out,
  input wire logic bus_clock_line_oe,
  input wire logic bus_data_line_in,
  input wire logic bus_data_line_out,
  input wire logic bus_data_line_oe,
  // status
  input wire logic cmd_ready,
  input wire logic busy_ff,
  input wire logic arb_lost_ff,
  input wire logic start_seen_ff,
  input wire logic stop_seen_ff,
  input wire logic [3:0] slave_bit_ff
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  a_pin_zero: assert property (!bus_clock_line_out && !bus_data_line_out)
    else $error("pin data not zero");
  a_off_release: assert property (!port_enable_bit [*2] |-> !bus_clock_line_oe && !bus_data_line_oe)
    else $error("pin pulled while disabled");
  a_ready_idle: assert property (cmd_ready |-> !$past(busy_ff) && $past(port_enable_bit))
    else $error("ready while bus busy");
  a_start_seen: assert property (port_enable_bit && bus_clock_line_in && $past(bus_clock_line_in)
    && $fell(bus_data_line_in) |-> ##[1:5] start_seen_ff) else $error("start missed");
  a_stop_seen: assert property (port_enable_bit && busy_ff && bus_clock_line_in && $past(bus_clock_line_in)
    && $rose(bus_data_line_in) |-> ##[1:5] stop_seen_ff) else $error("stop missed");
  a_bit_reset: assert property (start_seen_ff |-> ##[0:1] slave_bit_ff == 4'h0)
    else $error("bit count not cleared");
  a_arb_release: assert property ($rose(arb_lost_ff) |-> ##[0:2] !bus_data_line_oe && !bus_clock_line_oe)
    else $error("lines held after loss");
  a_stretch_wait: assert property (busy_ff && !bus_clock_line_oe && !bus_clock_line_in |=> !bus_clock_line_oe)
    else $error("clock pulled while stretched");
  c_start: cover property (start_seen_ff);
  c_stop: cover property (stop_seen_ff);
  c_lost: cover property ($rose(arb_lost_ff));
  c_stretch: cover property (busy_ff && !bus_clock_line_oe && !bus_clock_line_in);
endmodule
bind i2cbp_core i2cbp_core_props u_props (.clock, .rst_n, .port_enable_bit, .bus_clock_line_in,
  .bus_clock_line_out, .bus_clock_line_oe, .bus_data_line_in, .bus_data_line_out, .bus_data_line_oe,
  .cmd_ready, .busy_ff, .arb_lost_ff, .start_seen_ff, .stop_seen_ff, .slave_bit_ff);
`default_nettype wire

/* verif/i2cbp_peer.sv */
// behavioural slave on the far side of the bus
`timescale 1ns/1ps
`default_nettype none
module i2cbp_peer #(
  parameter logic [6:0] ADDR = 7'h2A
) (
  // bus wires
  input wire logic scl,
  input wire logic sda,
  output var logic scl_oe,
  output var logic sda_oe,
  // scenario controls
  input wire logic stretch,
  input wire logic clash,
  input wire logic talk,
  input wire logic [7:0] rd_byte,
  output var logic [7:0] got_byte
);
  int n = 0;
  logic [7:0] sh = 8'h00;
  logic sel = 1'b0;
  logic rd = 1'b0;
  logic ad = 1'b0;
  logic mk = 1'b1;
  logic nx = 1'b0;
  initial begin
    scl_oe = 1'b0;
    sda_oe = 1'b0;
    got_byte = 8'h00;
  end
  // start or repeated start clears byte logic
  always @(negedge sda) begin
    if (scl) begin
      n = 0;
      sel = 1'b0;
      rd = 1'b0;
      ad = 1'b1;
    end
  end
  // stop deselects
  always @(posedge sda) begin
    if (scl) sel = 1'b0;
  end
  // sample on the rising clock
  always @(posedge scl) begin
    if (n < 8) sh = {sh[6:0], sda};
    else if (rd) mk = sda;
    n = n + 1;
  end
  // drive while the clock is low, one assignment per edge; a clash pull is held 20000 ns and released with scl high
  always @(negedge scl) begin
    nx = 1'b0;
    if (clash && ad && n == 1) begin
      sda_oe = 1'b1;
      #20000 sda_oe = 1'b0;
    end else begin
      if (n == 8) begin
        got_byte = sh;
        if (ad) begin
          sel = sh[7:1] == ADDR;
          rd = sh[0];
        end
        nx = !talk && sel && (ad || !rd);
        ad = 1'b0;
      end else if (n == 9) begin
        n = 0;
        nx = sel && rd && !mk && !rd_byte[7];
      end else if (talk || sel && rd && !mk) begin
        nx = !rd_byte[7 - n];
      end
      sda_oe = nx;
      // hold the clock low mid-byte, past the master's release
      if (stretch && n == 4) begin
        scl_oe = 1'b1;
        #8000 scl_oe = 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

/* verif/i2cbp_core_tb.sv */
// self-checking bench for the two-wire protocol core
`timescale 1ns/1ps
`default_nettype none
module i2cbp_core_tb;
  localparam logic [6:0] ADDR = 7'h2A;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic en = 1'b1;
  logic cmd_valid = 1'b0;
  logic cmd_read = 1'b0;
  logic rx_ready = 1'b0;
  logic stretch = 1'b0;
  logic clash = 1'b0;
  logic talk = 1'b0;
  logic [7:0] cmd_data = 8'h00;
  logic [7:0] rd_byte = 8'h00;
  int mismatches = 0;
  int checks_done = 0;
  int cyc = 0;
  int starts = 0;
  int stops = 0;
  wire logic scl_oe, sda_oe, m_scl_oe, m_sda_oe, cmd_ready, rx_valid, busy_ff, nack_ff, arb_lost_ff, st_ff, sp_ff;
  wire logic [7:0] rx_data, got_byte;
  // open-drain lines with pull-ups
  wire logic scl = !(scl_oe || m_scl_oe);
  wire logic sda = !(sda_oe || m_sda_oe);
  i2cbp_core u_dut (.clock(clock), .rst_n(rst_n), .port_enable_bit(en), .bus_clock_line_in(scl),
    .bus_clock_line_out(), .bus_clock_line_oe(scl_oe), .bus_data_line_in(sda), .bus_data_line_out(),
    .bus_data_line_oe(sda_oe), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_start(1'b1), .cmd_stop(1'b1),
    .cmd_read(cmd_read), .cmd_ack(1'b1), .cmd_data(cmd_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
    .rx_data(rx_data), .busy_ff(busy_ff), .nack_ff(nack_ff), .arb_lost_ff(arb_lost_ff),
    .start_seen_ff(st_ff), .stop_seen_ff(sp_ff), .slave_bit_ff());
  i2cbp_peer #(.ADDR(ADDR)) u_peer (.scl(scl), .sda(sda), .scl_oe(m_scl_oe), .sda_oe(m_sda_oe),
    .stretch(stretch), .clash(clash), .talk(talk), .rd_byte(rd_byte), .got_byte(got_byte));
  // clock
  initial begin
    forever #25 clock = !clock;
  end
  // condition counters and hang guard
  always @(posedge clock) begin
    if (st_ff === 1'b1) starts <= starts + 1;
    if (sp_ff === 1'b1) stops <= stops + 1;
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      mismatches++;
      give_verdict;
    end
  end
  task automatic chk(input logic ok, input string msg);
    checks_done++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("unexpected %0t %s", $time, msg);
    end
  endtask
  // one message: start, byte, ack slot, stop
  task automatic send(input logic rd, input logic [7:0] d);
    int k;
    int s0;
    s0 = starts + stops;
    cmd_read = rd;
    cmd_data = d;
    cmd_valid = 1'b1;
    @(posedge clock);
    for (k = 0; k < 4000 && cmd_ready !== 1'b1; k++) @(posedge clock);
    #1 cmd_valid = 1'b0;
    for (k = 0; k < 4000 && sp_ff !== 1'b1; k++) @(posedge clock);
    repeat (60) @(posedge clock);
    #1 chk(starts + stops == s0 + 2, "not one start and one stop");
  endtask
  task automatic t_write;
    stretch = 1'b1;
    send(1'b0, {ADDR, 1'b0});
    chk(nack_ff === 1'b0, "present slave not acked");
    chk(got_byte === {ADDR, 1'b0}, "address bits out of order");
    send(1'b0, 8'hC4);
    chk(nack_ff === 1'b1, "absent slave acked");
    stretch = 1'b0;
    $display("write test done");
  endtask
  task automatic t_read;
    int k;
    int w;
    talk = 1'b1;
    rd_byte = 8'hA5;
    send(1'b1, 8'hFF);
    rd_byte = 8'h3C;
    send(1'b1, 8'hFF);
    chk(cmd_ready === 1'b0, "full buffer took a command");
    rx_ready = 1'b1;
    for (k = 0; k < 2; k++) begin
      for (w = 0; w < 20 && rx_valid !== 1'b1; w++) begin
        @(posedge clock);
        #1;
      end
      chk(rx_valid === 1'b1 && rx_data === (k == 0 ? 8'hA5 : 8'h3C), "received byte wrong");
      @(posedge clock);
      #1;
    end
    repeat (3) @(posedge clock);
    #1 chk(rx_valid === 1'b0, "buffer not empty");
    rx_ready = 1'b0;
    talk = 1'b0;
    $display("read test done");
  endtask
  task automatic t_arb;
    clash = 1'b1;
    send(1'b0, 8'hFE);
    chk(arb_lost_ff === 1'b1, "lost arbitration not flagged");
    chk(busy_ff === 1'b0 && cmd_ready === 1'b1, "bus not free after stop");
    clash = 1'b0;
    $display("arbitration test done");
  endtask
  task automatic t_off;
    cmd_valid = 1'b1;
    @(posedge clock);
    #1 cmd_valid = 1'b0;
    repeat (200) @(posedge clock);
    #1 en = 1'b0;
    repeat (3) @(posedge clock);
    #1 chk(scl_oe === 1'b0 && sda_oe === 1'b0 && cmd_ready === 1'b0, "disabled port active");
    en = 1'b1;
    $display("disable test done");
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (5) @(posedge clock);
    #1 rst_n = 1'b1;
    t_write;
    t_read;
    t_arb;
    t_off;
    give_verdict;
  end
endmodule
`default_nettype wire
